// *** design/acq_xfer_defs.vh ***
// How it works
// RQ1: increment mode permit drives converter result address
// RQ2: increment mode active asserts data-in and alter
// RQ3: memory cycle done clears active unless overflow
// RQ4: overflow starts second cycle; clear after it
// RQ5: list mode active bumps address, loads word one
// RQ6: first cycle end sets phase one, word two
// RQ7: second list cycle end clears active and phase
// RQ8: run-mode hold keeps DMA control in reset
// RQ9: field selects driven from field bits when active
// RQ10: accumulator mode pending result raises interrupt request
// RQ11: interrupt permit places trap address via trap bit
// RQ12: converter clear idles the accumulator interrupt circuit
// RQ13: three selects pick one of eight words, gated
// RQ14: twelve eight-input multiplexers drive data lines
// RQ15: K select on phase one for listed codes
// RQ16: data-in for 752 phases or 060 with qualifier
// RQ17: two mode bits select off, acc, increment, list
// RQ18: pending result raises DMA request; permit clears it
// RQ19: list address steps by two; full raises interrupt
// RQ20: interface strobes active low; idle after reset
// RQ21: one transfer at a time until converter clear
`ifndef ACQ_XFER_DEFS_VH
`define ACQ_XFER_DEFS_VH
`define MODE_OFF        2'h3
`define MODE_ACC        2'h2
`define MODE_INC        2'h1
`define MODE_LIST       2'h0
`define CODE_752        9'h1EA
`define CODE_202        9'h082
`define CODE_750        9'h1E8
`define CODE_060        9'h030
`define SRC_IDLE        3'h0
`define SRC_RESULT      3'h1
`define SRC_WORD1       3'h2
`define SRC_WORD2       3'h3
`define SRC_LIST        3'h4
`define SRC_TRAP        3'h5
`define TRAP_WORD       12'h040
`define LIST_STEP       11'h001
`define ST_IDLE         3'h0
`define ST_REQ          3'h1
`define ST_ACT          3'h2
`define ST_SECOND       3'h3
`define ST_DONE         3'h4
`define ST_INT          3'h5
`endif

// *** design/acquisition_transfer_control.v ***
`timescale 1ns/10ps
`include "acq_xfer_defs.vh"
module acquisition_transfer_control #(
  parameter WIDTH = 12
) (
  input  wire             mclk,
  input  wire             rst,
  input  wire             conversionPending,
  input  wire [WIDTH-1:0] converterResult,
  input  wire [WIDTH-1:0] listWordHigh,
  input  wire             acqModeBit0,
  input  wire             acqModeBit1,
  input  wire             fieldBitLow,
  input  wire             fieldBitHigh,
  input  wire             loadListAddr,
  input  wire [10:0]      listAddrInit,
  input  wire [10:0]      listAddrLast,
  input  wire             dmaPermit_n,
  input  wire             memoryCycleDone_n,
  input  wire             memoryOverflow_n,
  input  wire             runModeHold_n,
  input  wire             interruptPermit_n,
  input  wire             converterClear_n,
  input  wire             ioPulsePhaseOne,
  input  wire             ioPulsePhaseTwo,
  input  wire             auxIoQualifier,
  input  wire [8:0]       ioCode,
  output reg              dmaRequest_n,
  output reg              dmaActive,
  output reg              secondCycleStart_n,
  output reg              bufferPhaseOne_n,
  output reg              interruptRequest_n,
  output reg              trapBitLine_n,
  output reg              memoryAlterStrobe_n,
  output reg              dataInDirection_n,
  output reg              accumulatorKSelect_n,
  output reg              fieldSelectLow_n,
  output reg              fieldSelectHigh_n,
  output reg              listFull,
  output reg  [2:0]       sourceSelect,
  output reg  [WIDTH-1:0] dataLines
);
////////////////////////////////////////////////////////////////////////
// pin synchronisers, two flops each
localparam NS = 13;
localparam NC = 11;
wire [NS-1:0] s2Q;
wire [NS-1:0] pinRaw = {
  conversionPending,
  ~dmaPermit_n,
  ~memoryCycleDone_n,
  ~memoryOverflow_n,
  ~runModeHold_n,
  ~interruptPermit_n,
  ~converterClear_n,
  ioPulsePhaseOne,
  ioPulsePhaseTwo,
  auxIoQualifier,
  loadListAddr,
  acqModeBit0,
  acqModeBit1
};
pin_sync #(
  .W (NS)
) u_pinSync (
  .mclk   (mclk),
  .rst    (rst),
  .pinIn  (pinRaw),
  .pinOut (s2Q)
);
////////////////////////////////////////////////////////////////////////
// instruction code and field bits, two flops each
wire [NC-1:0] codeSync;
pin_sync #(
  .W (NC)
) u_codeSync (
  .mclk   (mclk),
  .rst    (rst),
  .pinIn  ({ioCode, fieldBitHigh, fieldBitLow}),
  .pinOut (codeSync)
);
wire [8:0] ioCodeS    = codeSync[10:2];
wire       fieldHighS = codeSync[1];
wire       fieldLowS  = codeSync[0];
wire pend   = s2Q[12];
wire permit = s2Q[11];
wire mdone  = s2Q[10];
wire ovfl   = s2Q[9];
wire hold   = s2Q[8];
wire iperm  = s2Q[7];
wire cclr   = s2Q[6];
wire ph1    = s2Q[5];
wire ph2    = s2Q[4];
wire auxq   = s2Q[3];
wire ldList = s2Q[2];
wire [1:0] mode = {s2Q[1], s2Q[0]};                          // RQ17
////////////////////////////////////////////////////////////////////////
// edge detect on synchronised strobes
reg permitQ;
reg mdoneQ;
always @(posedge mclk or posedge rst) begin
  if (rst) begin
    permitQ <= 1'b0;
    mdoneQ  <= 1'b0;
  end else begin
    permitQ <= permit;
    mdoneQ  <= mdone;
  end
end
wire permitEnd = permitQ & ~permit;
wire cycleEnd  = mdoneQ & ~mdone;
////////////////////////////////////////////////////////////////////////
// transfer sequencer
reg [2:0]  state_q;
reg [2:0]  state_d;
reg        phase_q;
reg        phase_d;
reg [10:0] listAddr_q;
reg        full_q;
wire dmaMode = (mode == `MODE_INC) | (mode == `MODE_LIST);
always @* begin
  state_d = state_q;
  phase_d = phase_q;
  case (state_q)
    `ST_IDLE: begin
      if (pend & dmaMode)
        state_d = `ST_REQ;                                   // RQ18
      else if (pend & (mode == `MODE_ACC))
        state_d = `ST_INT;                                   // RQ10
    end
    `ST_REQ: begin
      if (permitEnd)
        state_d = `ST_ACT;                                   // RQ18
    end
    `ST_ACT: begin
      if (cycleEnd) begin
        if (mode == `MODE_LIST) begin
          state_d = `ST_SECOND;                              // RQ6
          phase_d = 1'b1;                                    // RQ6
        end else if (ovfl)
          state_d = `ST_SECOND;                              // RQ4
        else
          state_d = `ST_DONE;                                // RQ3
      end
    end
    `ST_SECOND: begin
      if (cycleEnd) begin
        state_d = `ST_DONE;                                  // RQ7
        phase_d = 1'b0;                                      // RQ7
      end
    end
    `ST_DONE: begin
      if (cclr)
        state_d = `ST_IDLE;                                  // RQ21
    end
    `ST_INT: begin
      if (cclr)
        state_d = `ST_IDLE;                                  // RQ12
    end
    default: state_d = `ST_IDLE;
  endcase
end
wire dmaHold = hold & (state_q != `ST_INT);
always @(posedge mclk or posedge rst) begin
  if (rst) begin
    state_q <= `ST_IDLE;                                     // RQ20
    phase_q <= 1'b0;
  end else if (dmaHold) begin
    state_q <= `ST_IDLE;                                     // RQ8
    phase_q <= 1'b0;                                         // RQ8
  end else begin
    state_q <= state_d;
    phase_q <= phase_d;
  end
end
////////////////////////////////////////////////////////////////////////
// list address register, steps one word pair per event
wire enterAct = (state_q == `ST_REQ) & (state_d == `ST_ACT);
always @(posedge mclk or posedge rst) begin
  if (rst) begin
    listAddr_q <= 11'h000;
    full_q     <= 1'b0;
  end else if (ldList) begin
    listAddr_q <= listAddrInit;
    full_q     <= 1'b0;
  end else if (enterAct & (mode == `MODE_LIST)) begin
    listAddr_q <= listAddr_q + `LIST_STEP;                   // RQ5 RQ19
    if (listAddr_q == listAddrLast)
      full_q <= 1'b1;                                        // RQ19
  end
end
////////////////////////////////////////////////////////////////////////
// output multiplexer, one eight-input mux per bit
wire [WIDTH-1:0] listWord = {listAddr_q, 1'b0};
wire [WIDTH-1:0] srcWord [0:7];
assign srcWord[0] = {WIDTH{1'b0}};
assign srcWord[1] = converterResult;
assign srcWord[2] = listWordHigh;
assign srcWord[3] = converterResult;
assign srcWord[4] = listWord;
assign srcWord[5] = `TRAP_WORD;
assign srcWord[6] = {WIDTH{1'b0}};
assign srcWord[7] = {WIDTH{1'b0}};
reg [2:0] sel;
reg       readGate;
wire      active = (state_q == `ST_ACT) | (state_q == `ST_SECOND);
always @* begin
  sel      = `SRC_IDLE;
  readGate = 1'b0;
  if ((state_q == `ST_REQ) & permit & (mode == `MODE_INC)) begin
    sel      = `SRC_RESULT;                                  // RQ1
    readGate = 1'b1;
  end else if (active & (mode == `MODE_LIST)) begin
    sel      = phase_q ? `SRC_WORD1 : `SRC_LIST;             // RQ5 RQ6
    readGate = 1'b1;
  end else if ((state_q == `ST_INT) & (ph1 | ph2)) begin
    sel      = ph1 ? `SRC_WORD1 : `SRC_RESULT;
    readGate = 1'b1;
  end
end
wire [WIDTH-1:0] selWord;
genvar b;
generate
  for (b = 0; b < WIDTH; b = b + 1) begin : g_mux
    assign selWord[b] = srcWord[sel][b];                     // RQ14
  end
endgenerate
////////////////////////////////////////////////////////////////////////
// registered processor-side outputs, active low except dmaActive and listFull
wire kCode = (ioCodeS == `CODE_752) | (ioCodeS == `CODE_202) |
             (ioCodeS == `CODE_750) | (ioCodeS == `CODE_060);
wire dinIo = ((ioCodeS == `CODE_752) & (ph1 | ph2)) |
             ((ioCodeS == `CODE_060) & auxq);
wire trapOn = (state_q == `ST_INT) & iperm;
always @(posedge mclk or posedge rst) begin
  if (rst) begin
    dmaRequest_n         <= 1'b1;                            // RQ20
    dmaActive            <= 1'b0;
    secondCycleStart_n   <= 1'b1;
    bufferPhaseOne_n     <= 1'b1;
    interruptRequest_n   <= 1'b1;
    trapBitLine_n        <= 1'b1;
    memoryAlterStrobe_n  <= 1'b1;
    dataInDirection_n    <= 1'b1;
    accumulatorKSelect_n <= 1'b1;
    fieldSelectLow_n     <= 1'b1;
    fieldSelectHigh_n    <= 1'b1;
    listFull             <= 1'b0;
  end else begin
    dmaRequest_n <= ~((state_q == `ST_REQ) & ~permit);       // RQ18
    dmaActive    <= active;
    secondCycleStart_n <= ~(state_q == `ST_SECOND);          // RQ4
    bufferPhaseOne_n   <= ~phase_q;                          // RQ6
    interruptRequest_n <= ~((state_q == `ST_INT) | full_q);  // RQ10 RQ19
    trapBitLine_n      <= ~trapOn;                           // RQ11
    memoryAlterStrobe_n <= ~(active & (mode == `MODE_INC));  // RQ2
    dataInDirection_n <= ~((active & dmaMode) | dinIo);      // RQ2 RQ16
    accumulatorKSelect_n <= ~(kCode & ph1);                  // RQ15
    fieldSelectLow_n  <= ~(active & fieldLowS);              // RQ9
    fieldSelectHigh_n <= ~(active & fieldHighS);             // RQ9
    listFull     <= full_q;
  end
end
////////////////////////////////////////////////////////////////////////
// registered data path to the processor
always @(posedge mclk or posedge rst) begin
  if (rst) begin
    sourceSelect <= `SRC_IDLE;
    dataLines    <= {WIDTH{1'b0}};
  end else begin
    sourceSelect <= trapOn ? `SRC_TRAP : sel;                // RQ13
    if (trapOn)
      dataLines <= `TRAP_WORD;                               // RQ11
    else if (readGate)
      dataLines <= selWord;                                  // RQ13
    else
      dataLines <= {WIDTH{1'b0}};                            // RQ13
  end
end
endmodule // acquisition_transfer_control
////////////////////////////////////////////////////////////////////////
// two-flop synchroniser for a bus of unrelated pin levels
module pin_sync #(
  parameter W = 1
) (
  input  wire         mclk,
  input  wire         rst,
  input  wire [W-1:0] pinIn,
  output reg  [W-1:0] pinOut
);
reg [W-1:0] meta_q;
always @(posedge mclk or posedge rst) begin
  if (rst) begin
    meta_q <= {W{1'b0}};
    pinOut <= {W{1'b0}};
  end else begin
    meta_q <= pinIn;
    pinOut <= meta_q;
  end
end
endmodule // pin_sync

// *** test/acq_monitor.sv ***
`timescale 1ns/10ps
`include "acq_xfer_defs.vh"
module acq_monitor (
  input wire       mclk,
  input wire       rst,
  input wire       dmaRequest_n,
  input wire       dmaActive,
  input wire       dmaPermit_n,
  input wire       secondCycleStart_n,
  input wire       fieldSelectLow_n,
  input wire       fieldSelectHigh_n,
  input wire       runModeHold_n,
  input wire       interruptRequest_n,
  input wire       interruptPermit_n,
  input wire       trapBitLine_n,
  input wire       converterClear_n,
  input wire       accumulatorKSelect_n,
  input wire       ioPulsePhaseOne,
  input wire [8:0] ioCode,
  input wire       memoryAlterStrobe_n,
  input wire       acqModeBit0,
  input wire       acqModeBit1
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  property p_rst;
    disable iff (1'b0) rst |-> dmaRequest_n && !dmaActive && interruptRequest_n;
  endproperty
  property p_hold;
    !runModeHold_n [*6] |-> !dmaActive && dmaRequest_n;
  endproperty
  property p_perm;
    !dmaPermit_n [*5] |-> dmaRequest_n;
  endproperty
  property p_alt;
    $rose(dmaActive) && !acqModeBit0 && acqModeBit1 |->
      ##[0:2] !memoryAlterStrobe_n;
  endproperty
  property p_sec;
    $fell(secondCycleStart_n) |-> dmaActive;
  endproperty
  property p_fld;
    !dmaActive [*3] |-> fieldSelectLow_n && fieldSelectHigh_n;
  endproperty
  property p_trap;
    $fell(interruptPermit_n) && !interruptRequest_n |-> ##[2:8] !trapBitLine_n;
  endproperty
  property p_clr;
    !converterClear_n [*5] |-> interruptRequest_n;
  endproperty
  property p_ks;
    (ioPulsePhaseOne && ioCode == `CODE_202) [*4] |-> !accumulatorKSelect_n;
  endproperty
  a_rst: assert property (p_rst)
    else $error("outputs not idle in reset");
  a_hold: assert property (p_hold)
    else $error("dma active while run hold low");
  a_perm: assert property (p_perm)
    else $error("request not cleared by permit");
  a_alt: assert property (p_alt)
    else $error("alter strobe missing");
  a_sec: assert property (p_sec)
    else $error("second cycle without active");
  a_fld: assert property (p_fld)
    else $error("field select while idle");
  a_trap: assert property (p_trap)
    else $error("trap bit missing");
  a_clr: assert property (p_clr)
    else $error("interrupt request not cleared");
  a_ks: assert property (p_ks)
    else $error("k select missing");
  c_sec: cover property ($fell(secondCycleStart_n));
  c_trap: cover property ($fell(trapBitLine_n));
  c_dma: cover property ($fell(dmaActive));
endmodule // acq_monitor

// *** test/proc_model.sv ***
`timescale 1ns/10ps
module proc_model (
  input wire        mclk,
  input wire        dmaRequest_n,
  input wire        dmaActive,
  input wire        interruptRequest_n,
  input wire        ovf,
  input wire [11:0] dataLines,
  output reg        dmaPermit_n,
  output reg        memoryCycleDone_n,
  output reg        memoryOverflow_n,
  output reg        interruptPermit_n,
  output reg [11:0] wp,
  output reg [11:0] w1,
  output reg [11:0] w2,
  output reg [3:0]  n
);
  initial begin
    {dmaPermit_n, memoryCycleDone_n, memoryOverflow_n} = 3'h7;
    interruptPermit_n = 1'b1;
    n = 4'h0;
  end
  always begin
    @(posedge mclk);
    if (!dmaRequest_n) begin
      #1 dmaPermit_n = 1'b0;
      repeat (6) @(posedge mclk);
      wp = dataLines;
      #1 dmaPermit_n = 1'b1;
      n = 4'h0;
      repeat (8) @(posedge mclk);
      while (dmaActive && n < 4'h3) begin
        #1 memoryCycleDone_n = 1'b0;
        memoryOverflow_n = !(ovf && n == 4'h0);
        repeat (4) @(posedge mclk);
        if (n == 4'h0) w1 = dataLines;
        else w2 = dataLines;
        #1 memoryCycleDone_n = 1'b1;
        repeat (4) @(posedge mclk);
        #1 memoryOverflow_n = 1'b1;
        repeat (4) @(posedge mclk);
        n = n + 4'h1;
      end
    end
  end
  always begin
    @(posedge mclk);
    if (!interruptRequest_n) begin
      #1 interruptPermit_n = 1'b0;
      repeat (4) @(posedge mclk);
      #1 interruptPermit_n = 1'b1;
      wait (interruptRequest_n);
    end
  end
endmodule // proc_model

// *** test/tb_top.sv ***
`timescale 1ns/10ps
`include "acq_xfer_defs.vh"
module tb_top;
  reg mclk, rst, conversionPending, acqModeBit0, acqModeBit1, ovf;
  reg fieldBitLow, fieldBitHigh, loadListAddr, runModeHold_n;
  reg converterClear_n, ioPulsePhaseOne, ioPulsePhaseTwo, auxIoQualifier;
  reg [11:0] converterResult, listWordHigh, p;
  reg [10:0] listAddrInit, listAddrLast;
  reg [8:0]  ioCode;
  reg [35:0] cl;
  wire dmaPermit_n, memoryCycleDone_n, memoryOverflow_n, interruptPermit_n;
  wire dmaRequest_n, dmaActive, secondCycleStart_n, bufferPhaseOne_n;
  wire interruptRequest_n, trapBitLine_n, memoryAlterStrobe_n, listFull;
  wire dataInDirection_n, accumulatorKSelect_n;
  wire fieldSelectLow_n, fieldSelectHigh_n;
  wire [2:0]  sourceSelect;
  wire [11:0] dataLines, wp, w1, w2;
  wire [3:0]  n;
  integer compares, bad_count, i, j, cyc;
  acquisition_transfer_control uut (.*);
  proc_model pm (.*);
  ////////////////////////////////////////////////////////////////////////////
  task chk(input [11:0] e, input [11:0] s, input [8*8:1] nm);
    compares = compares + 1;
    if (s !== e) begin
      bad_count = bad_count + 1;
      $display("ERROR %0s expected %h seen %h", nm, e, s);
    end
  endtask
  task clk(input integer k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task clr;
    converterClear_n = 1'b0;
    clk(8);
    converterClear_n = 1'b1;
    clk(8);
  endtask
  task run(input b0, input b1, input o);
    acqModeBit0 = b0;
    acqModeBit1 = b1;
    ovf = o;
    conversionPending = 1'b1;
    for (i = 0; i < 60 && dmaActive !== 1'b1; i = i + 1) clk(1);
    chk({fieldSelectHigh_n, fieldSelectLow_n}, 12'h002, "field");
    chk(dataInDirection_n, 12'h000, "dmadin");
    for (i = 0; i < 200 && dmaActive !== 1'b0; i = i + 1) clk(1);
    conversionPending = 1'b0;
    clr;
  endtask
  task test_done;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      bad_count = bad_count + 1;
      test_done;
    end
  end
  initial begin
    {compares, bad_count, cyc} = 0;
    {rst, runModeHold_n, converterClear_n, acqModeBit0, acqModeBit1} = 5'h1F;
    {conversionPending, ovf, fieldBitLow, fieldBitHigh, loadListAddr} = 5'h0;
    {ioPulsePhaseOne, ioPulsePhaseTwo, auxIoQualifier} = 3'h0;
    {converterResult, listWordHigh, ioCode} = {12'hA53, 12'h3C6, 9'h000};
    {listAddrInit, listAddrLast} = {11'h005, 11'h7FF};
    cl = {`CODE_752, `CODE_202, `CODE_750, `CODE_060};
    clk(3);
    rst = 1'b0;
    chk({dmaRequest_n, interruptRequest_n, dmaActive}, 12'h006, "idle");
    loadListAddr = 1'b1;
    clk(4);
    loadListAddr = 1'b0;
    fieldBitLow = 1'b1;
    run(1'b0, 1'b1, 1'b0);
    chk(wp, 12'hA53, "address");
    chk(n, 12'h001, "cycles");
    run(1'b0, 1'b1, 1'b1);
    chk(n, 12'h002, "ovfcyc");
    run(1'b0, 1'b0, 1'b0);
    chk(n, 12'h002, "listcyc");
    chk(w2, listWordHigh, "word2");
    p = w1;
    run(1'b0, 1'b0, 1'b0);
    chk(w1 - p, 12'h002, "step");
    runModeHold_n = 1'b0;
    acqModeBit0 = 1'b0;
    conversionPending = 1'b1;
    clk(30);
    chk(dmaActive, 12'h000, "hold");
    conversionPending = 1'b0;
    runModeHold_n = 1'b1;
    clr;
    {acqModeBit0, acqModeBit1} = 2'b10;
    conversionPending = 1'b1;
    for (i = 0; i < 60 && trapBitLine_n !== 1'b0; i = i + 1) clk(1);
    chk(dataLines, `TRAP_WORD, "trap");
    chk(sourceSelect, `SRC_TRAP, "srcsel");
    chk(interruptRequest_n, 12'h000, "intreq");
    conversionPending = 1'b0;
    clr;
    chk(interruptRequest_n, 12'h001, "intclr");
    acqModeBit0 = 1'b1;
    for (j = 0; j < 4; j = j + 1) begin
      ioCode = cl[35 - 9 * j -: 9];
      ioPulsePhaseOne = 1'b1;
      clk(6);
      chk(accumulatorKSelect_n, 12'h000, "kselect");
      if (j == 0) chk(dataInDirection_n, 12'h000, "datain");
      ioPulsePhaseOne = 1'b0;
      clk(6);
    end
    test_done;
  end
endmodule // tb_top
bind acquisition_transfer_control acq_monitor mon (.*);
